// ---- core/rtto_pkg.sv ----
package rtto_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned PTR_W = 2;
  localparam int unsigned CNT_W = 3;
  localparam logic [CNT_W-1:0] STALL_LEVEL = 3'h3;
  localparam logic [3:0] PST_IDLE = 4'h0;
  localparam logic [3:0] PST_BRANCH = 4'h5;
  localparam logic [3:0] PST_STOP_BKPT = 4'he;
  localparam logic [3:0] PST_HALT = 4'hf;
  localparam logic [1:0] MARK_PREFIX = 2'h2;
  localparam logic [1:0] ADDR_SHOW_NONE = 2'h0;
  localparam logic [1:0] ADDR_SHOW_2 = 2'h1;
  localparam logic [1:0] ADDR_SHOW_3 = 2'h2;
  localparam logic [1:0] ADDR_SHOW_4 = 2'h3;
  localparam logic [1:0] BYTES_4 = 2'h3;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [2:0] NIB_IDX_RESET = 3'h0;
  typedef enum logic [1:0] {
    RTTO_ST_IDLE,
    RTTO_ST_MARK,
    RTTO_ST_DATA,
    RTTO_ST_BKVAL
  } rtto_state_t;
endpackage : rtto_pkg

// ---- core/rtto_port.sv ----
`timescale 1ns/1ps
// Operation
// R1 - Eight-bit port built from two nibbles
// R2 - Four-entry 32-bit capture FIFO
// R3 - Buffered values leave least significant nibble first
// R4 - Three entries valid stalls core until two free
// R5 - Taken branch shows status 0x5
// R6 - Capture targets only for variant-addressing branches
// R7 - Configured address bytes, marker just before nibbles
// R8 - Markers 0x9, 0xA, 0xB for 2/3/4 bytes
// R9 - Stopped core holds 0xE continuously
// R10 - Breakpoint change: one 0xE then left-justified status
// R11 - Status nibbles 0x0,0x2,0x4,0xA,0xC
// R12 - Halted drives 0xFF continuously
// R13 - Data always preceded by marker 0x8-0xB
// R14 - No 0xF straight after all-ones 4-byte data
// R15 - Receiver counts long 0xF runs as halt
// R16 - Upper nibble first, port at half rate
// R17 - Marker and data contiguous, idle otherwise
module rtto_port (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic branch_taken_in,
  input wire logic branch_variant_in,
  input wire logic [31:0] branch_target_in,
  input wire logic [1:0] addr_show_cfg_in,
  input wire logic data_capture_in,
  input wire logic [1:0] data_bytes_in,
  input wire logic [31:0] data_value_in,
  input wire logic data2_capture_in,
  input wire logic [31:0] data2_value_in,
  input wire logic stopped_in,
  input wire logic halted_in,
  input wire logic bkpt_change_in,
  input wire logic [2:0] breakpoint_trigger_status_in,
  output logic core_stall_out,
  output logic trace_clk_out,
  output logic [7:0] trace_status_data_port_out
);
  logic rst_meta_q;
  logic rst_n_q;

  // Reset released through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Entry: lead5, show, byte code, word
  logic [31:0] fifo_word_q [rtto_pkg::FIFO_DEPTH];
  logic [1:0] fifo_bytes_q [rtto_pkg::FIFO_DEPTH];
  logic [rtto_pkg::FIFO_DEPTH-1:0] fifo_lead_q;
  logic [rtto_pkg::FIFO_DEPTH-1:0] fifo_show_q;
  logic [rtto_pkg::PTR_W-1:0] wr_ptr_q;
  logic [rtto_pkg::PTR_W-1:0] rd_ptr_q;
  logic [rtto_pkg::CNT_W-1:0] count_q;
  logic [rtto_pkg::PTR_W-1:0] wr_ptr_b;
  logic push_a;
  logic push_b;
  logic a_lead;
  logic a_show;
  logic [1:0] a_bytes;
  logic [31:0] a_word;
  logic pop;
  logic [rtto_pkg::CNT_W-1:0] push_cnt;

  // Only variant-addressing branches carry a target
  always_comb
  begin
    a_lead = 1'b0;
    a_show = 1'b0;
    a_bytes = data_bytes_in;
    a_word = data_value_in;
    push_a = 1'b0;
    if (branch_taken_in)
    begin
      push_a = 1'b1; // R5
      a_lead = 1'b1;
      a_show = branch_variant_in && (addr_show_cfg_in != rtto_pkg::ADDR_SHOW_NONE); // R6 R7
      a_bytes = addr_show_cfg_in; // R8
      a_word = branch_target_in;
    end
    else if (data_capture_in)
    begin
      push_a = 1'b1;
      a_show = 1'b1;
    end
  end

  assign push_b = data2_capture_in;
  assign wr_ptr_b = push_a ? wr_ptr_q + 2'h1 : wr_ptr_q;
  assign push_cnt = {2'h0, push_a} + {2'h0, push_b};

  // Read-modify-write may push two; core honours stall before that
  always_ff @(posedge core_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wr_ptr_q <= '0;
      fifo_lead_q <= '0;
      fifo_show_q <= '0;
      for (int i = 0; i < rtto_pkg::FIFO_DEPTH; i++)
      begin
        fifo_word_q[i] <= '0;
        fifo_bytes_q[i] <= '0;
      end
    end
    else
    begin
      if (push_a)
      begin
        fifo_word_q[wr_ptr_q] <= a_word; // R2
        fifo_bytes_q[wr_ptr_q] <= a_bytes;
        fifo_lead_q[wr_ptr_q] <= a_lead;
        fifo_show_q[wr_ptr_q] <= a_show;
      end
      if (push_b)
      begin
        fifo_word_q[wr_ptr_b] <= data2_value_in; // R2
        fifo_bytes_q[wr_ptr_b] <= data_bytes_in;
        fifo_lead_q[wr_ptr_b] <= 1'b0;
        fifo_show_q[wr_ptr_b] <= 1'b1;
      end
      wr_ptr_q <= wr_ptr_q + push_cnt[rtto_pkg::PTR_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (pop)
        rd_ptr_q <= rd_ptr_q + 2'h1;
      count_q <= count_q + push_cnt - {2'h0, pop};
    end
  end

  // Stall from three valid until two are free again
  assign core_stall_out = (count_q >= rtto_pkg::STALL_LEVEL); // R4

  // Breakpoint change held until sent; new change wins over the clear
  logic bk_pend_q;
  logic [2:0] bk_stat_q;
  logic bk_take;

  always_ff @(posedge core_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      bk_pend_q <= 1'b0;
      bk_stat_q <= '0;
    end
    else
    begin
      if (bkpt_change_in)
      begin
        bk_pend_q <= 1'b1;
        bk_stat_q <= breakpoint_trigger_status_in;
      end
      else if (bk_take)
        bk_pend_q <= 1'b0;
    end
  end

  // Nibble sequencer, one nibble per core cycle
  rtto_pkg::rtto_state_t state_q;
  rtto_pkg::rtto_state_t state_d;
  logic [2:0] nib_idx_q;
  logic [2:0] nib_idx_d;
  logic ones_q;
  logic ones_d;
  logic [3:0] nib;
  logic [31:0] head_word;
  logic [1:0] head_bytes;
  logic [2:0] last_idx;

  assign head_word = fifo_word_q[rd_ptr_q];
  assign head_bytes = fifo_bytes_q[rd_ptr_q];
  assign last_idx = {head_bytes, 1'b1};

  always_comb
  begin
    state_d = state_q;
    nib_idx_d = nib_idx_q;
    ones_d = ones_q;
    nib = rtto_pkg::PST_IDLE;
    pop = 1'b0;
    bk_take = 1'b0;
    case (state_q)
      rtto_pkg::RTTO_ST_IDLE:
      begin
        ones_d = 1'b0;
        if (halted_in && ones_q)
          nib = rtto_pkg::PST_IDLE; // R14
        else if (halted_in)
          nib = rtto_pkg::PST_HALT; // R12
        else if (bk_pend_q)
        begin
          nib = rtto_pkg::PST_STOP_BKPT; // R10
          bk_take = 1'b1;
          state_d = rtto_pkg::RTTO_ST_BKVAL;
        end
        else if (count_q != '0)
        begin
          nib_idx_d = rtto_pkg::NIB_IDX_RESET;
          if (fifo_lead_q[rd_ptr_q])
          begin
            nib = rtto_pkg::PST_BRANCH; // R5
            if (fifo_show_q[rd_ptr_q])
              state_d = rtto_pkg::RTTO_ST_MARK; // R17
            else
              pop = 1'b1;
          end
          else
          begin
            nib = {rtto_pkg::MARK_PREFIX, head_bytes}; // R13
            state_d = rtto_pkg::RTTO_ST_DATA;
          end
        end
        else if (stopped_in)
          nib = rtto_pkg::PST_STOP_BKPT; // R9
      end
      rtto_pkg::RTTO_ST_MARK:
      begin
        nib = {rtto_pkg::MARK_PREFIX, head_bytes}; // R7 R8 R13
        state_d = rtto_pkg::RTTO_ST_DATA;
      end
      rtto_pkg::RTTO_ST_DATA:
      begin
        nib = head_word[{nib_idx_q, 2'h0} +: 4]; // R3
        nib_idx_d = nib_idx_q + 3'h1;
        if (nib_idx_q == last_idx)
        begin
          pop = 1'b1;
          nib_idx_d = rtto_pkg::NIB_IDX_RESET;
          state_d = rtto_pkg::RTTO_ST_IDLE;
          ones_d = (head_bytes == rtto_pkg::BYTES_4) && (&head_word); // R14
        end
      end
      rtto_pkg::RTTO_ST_BKVAL:
      begin
        nib = {bk_stat_q, 1'b0}; // R10 R11
        state_d = rtto_pkg::RTTO_ST_IDLE;
      end
      default:
      begin
        state_d = rtto_pkg::RTTO_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= rtto_pkg::RTTO_ST_IDLE;
      nib_idx_q <= rtto_pkg::NIB_IDX_RESET;
      ones_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      nib_idx_q <= nib_idx_d;
      ones_q <= ones_d;
    end
  end

  // Pairing: first nibble held, both shown together for two cycles
  logic phase_q;
  logic [3:0] hi_q;
  logic [7:0] port_q;

  always_ff @(posedge core_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      phase_q <= 1'b0;
      hi_q <= rtto_pkg::NIB_RESET;
      port_q <= rtto_pkg::PORT_RESET;
    end
    else
    begin
      phase_q <= ~phase_q; // R16
      if (!phase_q)
        hi_q <= nib;
      else
        port_q <= {hi_q, nib}; // R1 R16
    end
  end

  assign trace_status_data_port_out = port_q;
  assign trace_clk_out = phase_q;
endmodule : rtto_port

// ---- test/rtto_port_sva.sv ----
`timescale 1ns/1ps
module rtto_port_sva (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic branch_taken_in,
  input wire logic stopped_in,
  input wire logic halted_in,
  input wire logic bkpt_change_in,
  input wire logic core_stall_out,
  input wire logic trace_clk_out,
  input wire logic [7:0] trace_status_data_port_out
);
  logic [2:0] up_q;
  logic [7:0] p;
  logic ok;
  logic [3:0] ff_run_q;
  assign p = trace_status_data_port_out;
  assign ok = (up_q == 3'h7);
  // Internal reset lags the pin by two flops, so wait it out
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      up_q <= 3'h0;
    else if (!ok)
      up_q <= up_q + 3'h1;
  end
  // All-ones data gives at most eight 0xFF samples, so nine means halt
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ff_run_q <= 4'h0;
    else if (p != 8'hff)
      ff_run_q <= 4'h0;
    else if (ff_run_q != 4'hf)
      ff_run_q <= ff_run_q + 4'h1;
  end
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  a_trace_clk_toggle: assert property (ok |-> trace_clk_out != $past(trace_clk_out))
    else $error("trace clock did not toggle");
  a_port_pair_hold: assert property (ok && $changed(p) |=> $stable(p))
    else $error("port value held one cycle");
  a_stall_clears: assert property ($rose(core_stall_out) |-> ##[1:100] !core_stall_out)
    else $error("stall never released");
  a_halt_shows_ff: assert property ($rose(halted_in) |-> ##[1:60] p == 8'hff)
    else $error("halt pattern missing");
  a_halt_holds_ff: assert property (ok && halted_in && $past(halted_in) && $past(halted_in, 2) && $past(halted_in, 3)
    && ff_run_q >= 4'h9 |-> p == 8'hff)
    else $error("halt pattern broken");
  a_stop_shows_ee: assert property ($rose(stopped_in) && !halted_in |-> ##[1:60] p == 8'hee)
    else $error("stop pattern missing");
  a_branch_code: assert property (branch_taken_in && !halted_in && !stopped_in
    |-> ##[1:40] (p[7:4] == 4'h5 || p[3:0] == 4'h5))
    else $error("taken branch code missing");
  a_bkpt_code: assert property (bkpt_change_in && !halted_in
    |-> ##[1:40] (p[7:4] == 4'he || p[3:0] == 4'he))
    else $error("breakpoint code missing");
endmodule : rtto_port_sva
bind rtto_port rtto_port_sva u_sva (
  .core_clk_in(core_clk_in),
  .arst_n_in(arst_n_in),
  .branch_taken_in(branch_taken_in),
  .stopped_in(stopped_in),
  .halted_in(halted_in),
  .bkpt_change_in(bkpt_change_in),
  .core_stall_out(core_stall_out),
  .trace_clk_out(trace_clk_out),
  .trace_status_data_port_out(trace_status_data_port_out)
);

// ---- test/rtto_port_test.sv ----
`timescale 1ns/1ps
module rtto_port_test;
  logic core_clk_in = '0, arst_n_in = '0, branch_taken_in = '0, branch_variant_in = '0, data_capture_in = '0;
  logic data2_capture_in = '0, stopped_in = '0, halted_in = '0, bkpt_change_in = '0;
  logic core_stall_out, trace_clk_out;
  logic [1:0] addr_show_cfg_in = '0, data_bytes_in = '0;
  logic [2:0] breakpoint_trigger_status_in = '0;
  logic [7:0] trace_status_data_port_out;
  logic [31:0] branch_target_in = 32'h8765_4321, data_value_in = '0, data2_value_in = '0;
  int mismatches = 0, checked = 0;
  rtto_port u_dut (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .branch_taken_in(branch_taken_in),
    .branch_variant_in(branch_variant_in),
    .branch_target_in(branch_target_in),
    .addr_show_cfg_in(addr_show_cfg_in),
    .data_capture_in(data_capture_in),
    .data_bytes_in(data_bytes_in),
    .data_value_in(data_value_in),
    .data2_capture_in(data2_capture_in),
    .data2_value_in(data2_value_in),
    .stopped_in(stopped_in),
    .halted_in(halted_in),
    .bkpt_change_in(bkpt_change_in),
    .breakpoint_trigger_status_in(breakpoint_trigger_status_in),
    .core_stall_out(core_stall_out),
    .trace_clk_out(trace_clk_out),
    .trace_status_data_port_out(trace_status_data_port_out)
  );
  rtto_rx_model u_rx (
    .core_clk_in(core_clk_in),
    .trace_clk_out(trace_clk_out),
    .trace_status_data_port_out(trace_status_data_port_out)
  );
  always #2.5 core_clk_in = ~core_clk_in;
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : step
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("unexpected at %0t: %h not %h", $time, seen, want);
    end
  endtask : check
  function automatic logic [7:0] nq(input int i);
    return {4'h0, u_rx.nib_q[i]};
  endfunction : nq
  function automatic int find(input logic [3:0] v);
    int i;
    for (i = 0; i < u_rx.nib_q.size(); i++)
      if (u_rx.nib_q[i] === v)
        break;
    return i;
  endfunction : find
  function automatic logic [7:0] cnt(input logic [3:0] v);
    logic [7:0] c;
    c = 8'h00;
    foreach (u_rx.nib_q[i])
      if (u_rx.nib_q[i] === v)
        c = c + 8'h01;
    return c;
  endfunction : cnt
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse
  task automatic t_branch;
    int k;
    for (int c = 0; c < 5; c++)
    begin
      u_rx.nib_q = {};
      addr_show_cfg_in = (c == 4) ? 2'h3 : c[1:0];
      branch_variant_in = (c != 4);
      pulse(branch_taken_in);
      step(30);
      k = find(4'h5);
      check(nq(k), 8'h05);
      check(nq(k + 1), (c % 4 == 0) ? 8'h00 : 8'h08 + c[7:0]);
      for (int j = 0; c % 4 != 0 && j < 2 * c + 2; j++)
        check(nq(k + 2 + j), {4'h0, branch_target_in[4 * j +: 4]});
    end
    $display("branch test done");
  endtask : t_branch
  task automatic t_bkpt;
    logic [2:0] sv [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic [7:0] ev [5] = '{8'h00, 8'h02, 8'h04, 8'h0a, 8'h0c};
    int k;
    for (int i = 0; i < 5; i++)
    begin
      u_rx.nib_q = {};
      breakpoint_trigger_status_in = sv[i];
      pulse(bkpt_change_in);
      step(20);
      k = find(4'he);
      check(nq(k + 1), ev[i]);
      check(nq(k + 2), 8'h00);
    end
    $display("breakpoint test done");
  endtask : t_bkpt
  task automatic t_rmw;
    int n;
    data_bytes_in = 2'h3;
    u_rx.nib_q = {};
    addr_show_cfg_in = 2'h0;
    pulse(data_capture_in);
    pulse(branch_taken_in);
    // Two captures while the first word is still on the port
    data_capture_in = 1'b1;
    data2_capture_in = 1'b1;
    step(1);
    data_capture_in = 1'b0;
    data2_capture_in = 1'b0;
    check({7'h0, core_stall_out}, 8'h01);
    for (n = 0; n < 100 && core_stall_out !== 1'b0; n++)
      step(1);
    check({7'h0, core_stall_out}, 8'h00);
    step(60);
    check(cnt(4'hb), 8'h03);
    check(cnt(4'h5), 8'h01);
    u_rx.nib_q = {};
    data_value_in = 32'hffff_ffff;
    pulse(data_capture_in);
    step(2);
    halted_in = 1'b1;
    step(40);
    n = find(4'hb);
    for (int j = 1; j < 9; j++)
      check(nq(n + j), 8'h0f);
    check({7'h0, nq(n + 9) == 8'h0f}, 8'h00);
    check(trace_status_data_port_out, 8'hff);
    check({7'h0, u_rx.halt_seen}, 8'h01);
    halted_in = 1'b0;
    step(10);
    $display("fifo and halt test done");
  endtask : t_rmw
  task automatic t_stop;
    logic prev;
    stopped_in = 1'b1;
    step(30);
    check(trace_status_data_port_out, 8'hee);
    prev = trace_clk_out;
    step(1);
    check({7'h0, trace_clk_out ^ prev}, 8'h01);
    stopped_in = 1'b0;
    step(10);
    $display("stop test done");
  endtask : t_stop
  task automatic tally_and_finish;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    step(2);
    arst_n_in = 1'b1;
    step(3);
    t_branch();
    t_bkpt();
    t_rmw();
    t_stop();
    tally_and_finish();
  end
  initial
  begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
endmodule : rtto_port_test

// ---- test/rtto_rx_model.sv ----
`timescale 1ns/1ps
module rtto_rx_model (
  input wire logic core_clk_in,
  input wire logic trace_clk_out,
  input wire logic [7:0] trace_status_data_port_out
);
  logic [3:0] nib_q [$];
  logic halt_seen = 1'b0;
  int f_run = 0;
  // One sample per port value; either phase works as the pair stands two cycles
  always @(posedge core_clk_in)
  begin
    if (trace_clk_out === 1'b1)
    begin
      for (int i = 1; i >= 0; i--)
      begin
        nib_q.push_back(trace_status_data_port_out[4 * i +: 4]);
        f_run = (trace_status_data_port_out[4 * i +: 4] == 4'hf) ? f_run + 1 : 0;
        // Data runs of 0xF stop at eight, so nine means halt
        if (f_run >= 9)
          halt_seen = 1'b1;
      end
    end
  end
endmodule : rtto_rx_model
